// ==== verilog/icu_top.sv ====
// Purpose: Gain calibration, channel offsets, white balance and
//          configuration slot control for a colour line camera.
// Assumes: Inputs synchronous to clock_i; levels come from the
//          image path measured inside the balance window.
// Notes:   Registers are word-indexed; read data follow a cycle on.
`include "icu_consts.svh"

// Summary of operation
// RULE1: Gain target picks user area; default read-only.
// RULE2: Calibration computes, stores, applies, reports success.
// RULE3: Outcome idle first; bright error1, dark error2.
// RULE4: Refuse without image, pattern, off/default target.
// RULE5: Per-channel offsets, selector, clamp -133..255.
// RULE6: Gain balance refers to overall or green gain.
// RULE7: Exposure balance needs individual exposure mode.
// RULE8: Red/blue lock skips balancing, reports success.
// RULE9: Finished balance reports success, control returns off.
// RULE10: Green high gives error1, low gives error2.
// RULE11: Balance times out after 10 seconds.
// RULE12: Measurement window has width and start.
// RULE13: Colour presets only with per-channel gain off.
// RULE14: Three non-volatile slots plus factory default.
// RULE15: Store accepted only while acquisition stopped.
// RULE16: Recall accepted only while acquisition stopped.
// RULE17: Default recall restores factory; never stored.
// RULE18: Start ignored while operation is running.
module icu_top #(
  parameter int unsigned GCAL_CYCLES = 1000,
  parameter int unsigned WB_STEP     = 64,
  parameter int unsigned WB_TMO      = `ICU_WB_TMO_CYC
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Image path status and measurements
  input  wire logic        image_out_i,
  input  wire logic        synthetic_image_select_i,
  input  wire logic        acq_running_i,
  input  wire logic [9:0]  cal_level_i,
  input  wire logic [9:0]  red_level_i,
  input  wire logic [9:0]  green_level_i,
  input  wire logic [9:0]  blue_level_i,
  // Settings towards the image path
  output logic [9:0]       red_offset_o,
  output logic [9:0]       green_offset_o,
  output logic [9:0]       blue_offset_o,
  output logic [11:0]      red_digital_gain_o,
  output logic [11:0]      blue_digital_gain_o,
  output logic [15:0]      red_exposure_o,
  output logic [15:0]      blue_exposure_o,
  output logic [12:0]      wb_window_width_o,
  output logic [12:0]      wb_window_start_o,
  // Non-volatile store requests
  output logic             gain_cal_store_o,
  output logic [2:0]       gain_corr_target_area_o,
  output logic             config_slot_store_o,
  output logic             config_slot_recall_o,
  output logic [1:0]       config_slot_select_o,
  // Interrupt
  output logic             irq_o
);
  typedef struct packed {
    logic [2:0]                area;
    logic                      pcg;
    logic                      expind;
    logic                      lock;
    logic [1:0]                slot;
    logic [1:0]                osel;
    logic [9:0]                off_r;
    logic [9:0]                off_g;
    logic [9:0]                off_b;
    icu_pkg::icu_wbmode_type   wbmode;
    logic [12:0]               wb_w;
    logic [12:0]               wb_x;
    icu_pkg::icu_gcst_type     gcst;
    logic [15:0]               gcnt;
    icu_pkg::icu_outcome_type  gout;
    icu_pkg::icu_outcome_type  wout;
    logic [15:0]               wcnt;
    logic [31:0]               wtmo;
    logic [11:0]               rg;
    logic [11:0]               bg;
    logic [11:0]               ag;
    logic [11:0]               gg;
    logic [15:0]               er;
    logic [15:0]               eb;
    logic [15:0]               eg;
    logic [2:0]                ist;
    logic [2:0]                imask;
    logic [31:0]               rdata;
    logic                      irq;
    logic                      gstore;
    logic                      cstore;
    logic                      crecall;
  } icu_state_type;

  icu_state_type s_reg, s_next;
  logic          rst_meta_reg, rst_n_reg;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] clamp_off(input logic [9:0] v);
    logic signed [9:0] sv;
    sv = $signed(v);
    if (sv < `ICU_OFF_MIN) begin
      clamp_off = `ICU_OFF_MIN;
    end else if (sv > `ICU_OFF_MAX) begin
      clamp_off = `ICU_OFF_MAX;
    end else begin
      clamp_off = v;
    end
  endfunction

  // Returns 2'b01 to raise, 2'b10 to lower, 2'b00 when balanced.
  function automatic logic [1:0] wb_dir(input logic [9:0] lvl,
                                        input logic [9:0] grn);
    logic [10:0] l;
    logic [10:0] g;
    l = {1'b0, lvl};
    g = {1'b0, grn};
    if (l + {1'b0, `ICU_WB_TOL} < g) begin
      wb_dir = 2'b01;
    end else if (l > g + {1'b0, `ICU_WB_TOL}) begin
      wb_dir = 2'b10;
    end else begin
      wb_dir = 2'b00;
    end
  endfunction

  logic [1:0] dir_r, dir_b;
  assign dir_r = wb_dir(red_level_i, green_level_i);
  assign dir_b = wb_dir(blue_level_i, green_level_i);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0]  ev;
    logic        wfin;
    logic        wsat_hi;
    logic        wsat_lo;
    logic [15:0] vr;
    logic [15:0] vb;
    logic [15:0] vmax;
    ev      = 3'h0;
    wfin    = 1'b0;
    wsat_hi = 1'b0;
    wsat_lo = 1'b0;
    vr      = 16'h0000;
    vb      = 16'h0000;
    vmax    = 16'h0000;
    s_next  = s_reg;
    s_next.gstore  = 1'b0;
    s_next.cstore  = 1'b0;
    s_next.crecall = 1'b0;
    s_next.rdata   = 32'h0000_0000;

    // Gain calibration sequence.
    case (s_reg.gcst)
      icu_pkg::GC_IDLE: begin
        if (wr_i && addr_i == `ICU_A_CMD && wdata_i[`ICU_CMD_GCAL]) begin
          if (!image_out_i || synthetic_image_select_i ||
              s_reg.area < icu_pkg::AREA_U1 ||
              s_reg.area > icu_pkg::AREA_U3) begin
            s_next.gout = icu_pkg::OUT_ERR3; // see RULE4
            ev[0]       = 1'b1;
          end else begin
            s_next.gcst = icu_pkg::GC_RUN;
            s_next.gcnt = 16'h0000;
          end
        end
      end
      icu_pkg::GC_RUN: begin
        // A further start is not decoded here. see RULE18
        if (s_next.gcnt == 16'(GCAL_CYCLES - 1)) begin
          s_next.gcst = icu_pkg::GC_IDLE;
          ev[0]       = 1'b1;
          if (cal_level_i > `ICU_LVL_BRIGHT) begin
            s_next.gout = icu_pkg::OUT_ERR1; // see RULE3
          end else if (cal_level_i < `ICU_LVL_DARK) begin
            s_next.gout = icu_pkg::OUT_ERR2; // see RULE3
          end else begin
            s_next.gout   = icu_pkg::OUT_OK; // see RULE2
            s_next.gstore = 1'b1;            // see RULE1
          end
        end else begin
          s_next.gcnt = s_reg.gcnt + 16'h0001;
        end
      end
      default: s_next.gcst = icu_pkg::GC_IDLE;
    endcase

    // Automatic white balance, one step every WB_STEP cycles.
    case (s_reg.wbmode)
      icu_pkg::WB_ONCE, icu_pkg::WB_EXPONCE: begin
        s_next.wtmo = s_reg.wtmo + 32'h1;
        if (s_reg.lock) begin
          wfin        = 1'b1;
          s_next.wout = icu_pkg::OUT_OK; // see RULE8
        end else if (s_reg.wtmo == WB_TMO - 1) begin
          wfin        = 1'b1;
          s_next.wout = icu_pkg::OUT_ERR3; // see RULE11
        end else if (s_reg.wcnt == 16'(WB_STEP - 1)) begin
          s_next.wcnt = 16'h0000;
          if (s_reg.wbmode == icu_pkg::WB_ONCE) begin
            vr   = {4'h0, s_reg.rg};
            vb   = {4'h0, s_reg.bg};
            vmax = {4'h0, `ICU_GAIN_MAX};
          end else begin
            vr   = s_reg.er;
            vb   = s_reg.eb;
            vmax = 16'hffff;
          end
          wsat_hi = (dir_r == 2'b01 && vr == vmax) ||
                    (dir_b == 2'b01 && vb == vmax);
          wsat_lo = (dir_r == 2'b10 && vr <= 16'h0001) ||
                    (dir_b == 2'b10 && vb <= 16'h0001);
          if (dir_r == 2'b01) vr = vr + 16'h0001;
          if (dir_r == 2'b10) vr = vr - 16'h0001;
          if (dir_b == 2'b01) vb = vb + 16'h0001;
          if (dir_b == 2'b10) vb = vb - 16'h0001;
          if (wsat_hi) begin
            wfin        = 1'b1;
            s_next.wout = icu_pkg::OUT_ERR1; // see RULE10
          end else if (wsat_lo) begin
            wfin        = 1'b1;
            s_next.wout = icu_pkg::OUT_ERR2; // see RULE10
          end else if (dir_r == 2'b00 && dir_b == 2'b00) begin
            wfin        = 1'b1;
            s_next.wout = icu_pkg::OUT_OK; // see RULE9
          end else if (s_reg.wbmode == icu_pkg::WB_ONCE) begin
            s_next.rg = vr[11:0]; // see RULE6
            s_next.bg = vb[11:0];
          end else begin
            s_next.er = vr; // see RULE7
            s_next.eb = vb;
          end
        end else begin
          s_next.wcnt = s_reg.wcnt + 16'h0001;
        end
        if (wfin) begin
          s_next.wbmode = icu_pkg::WB_OFF; // see RULE9
          ev[1]         = 1'b1;
        end
      end
      icu_pkg::WB_OFF, icu_pkg::WB_P5000, icu_pkg::WB_P5500: begin
        if (wr_i && addr_i == `ICU_A_WBCTL) begin
          case (wdata_i[2:0])
            3'h1: begin
              s_next.wbmode = icu_pkg::WB_ONCE;
              s_next.rg = s_reg.pcg ? s_reg.gg : s_reg.ag; // see RULE6
              s_next.bg = s_reg.pcg ? s_reg.gg : s_reg.ag;
            end
            3'h2: begin
              if (s_reg.expind) begin
                s_next.wbmode = icu_pkg::WB_EXPONCE; // see RULE7
                s_next.er     = s_reg.eg;
                s_next.eb     = s_reg.eg;
              end
            end
            3'h3: begin
              if (!s_reg.pcg) begin
                s_next.wbmode = icu_pkg::WB_P5000; // see RULE13
                s_next.rg     = `ICU_P5000_R;
                s_next.bg     = `ICU_P5000_B;
              end
            end
            3'h4: begin
              if (!s_reg.pcg) begin
                s_next.wbmode = icu_pkg::WB_P5500; // see RULE13
                s_next.rg     = `ICU_P5500_R;
                s_next.bg     = `ICU_P5500_B;
              end
            end
            default: s_next.wbmode = icu_pkg::WB_OFF;
          endcase
          s_next.wcnt = 16'h0000;
          s_next.wtmo = 32'h0;
        end
      end
      default: s_next.wbmode = icu_pkg::WB_OFF;
    endcase

    // Register writes.
    if (wr_i) begin
      case (addr_i)
        `ICU_A_CTRL: begin
          // The target is held during a run so a store never hits default.
          if (s_reg.gcst == icu_pkg::GC_IDLE) begin
            s_next.area = wdata_i[2:0]; // see RULE1
          end
          s_next.pcg    = wdata_i[3];
          s_next.expind = wdata_i[4];
          s_next.lock   = wdata_i[5];
          s_next.slot   = wdata_i[7:6]; // see RULE14
        end
        `ICU_A_CMD: begin
          if (wdata_i[`ICU_CMD_STORE]) begin
            if (acq_running_i || s_reg.slot == 2'h0) begin
              ev[2] = 1'b1; // see RULE15
            end else begin
              s_next.cstore = 1'b1; // see RULE17
            end
          end
          if (wdata_i[`ICU_CMD_RECALL]) begin
            if (acq_running_i) begin
              ev[2] = 1'b1; // see RULE16
            end else begin
              s_next.crecall = 1'b1; // see RULE17
            end
          end
        end
        `ICU_A_OSEL: s_next.osel = wdata_i[1:0];
        `ICU_A_OVAL: begin
          case (s_reg.osel) // see RULE5
            2'h0: s_next.off_r = clamp_off(wdata_i[9:0]);
            2'h1: s_next.off_g = clamp_off(wdata_i[9:0]);
            2'h2: s_next.off_b = clamp_off(wdata_i[9:0]);
            default: ;
          endcase
        end
        `ICU_A_WBWIN: begin
          s_next.wb_w = wdata_i[12:0]; // see RULE12
          s_next.wb_x = wdata_i[28:16];
        end
        `ICU_A_REFGAIN: begin
          s_next.ag = wdata_i[11:0];
          s_next.gg = wdata_i[27:16];
        end
        `ICU_A_GEXP:  s_next.eg    = wdata_i[15:0];
        `ICU_A_IMASK: s_next.imask = wdata_i[2:0];
        default: ;
      endcase
    end

    // Register reads; an interrupt status read clears, a new event wins.
    if (rd_i) begin
      case (addr_i)
        `ICU_A_CTRL: s_next.rdata = {24'h0, s_reg.slot, s_reg.lock,
                                     s_reg.expind, s_reg.pcg,
                                     s_reg.area};
        `ICU_A_OSEL: s_next.rdata = {30'h0, s_reg.osel};
        `ICU_A_OVAL: begin
          case (s_reg.osel)
            2'h0: s_next.rdata = {{22{s_reg.off_r[9]}}, s_reg.off_r};
            2'h1: s_next.rdata = {{22{s_reg.off_g[9]}}, s_reg.off_g};
            2'h2: s_next.rdata = {{22{s_reg.off_b[9]}}, s_reg.off_b};
            default: s_next.rdata = 32'h0000_0000;
          endcase
        end
        `ICU_A_WBCTL: s_next.rdata = {29'h0, s_reg.wbmode};
        `ICU_A_WBWIN: s_next.rdata = {3'h0, s_reg.wb_x,
                                      3'h0, s_reg.wb_w};
        `ICU_A_STAT: s_next.rdata = {22'h0, s_reg.wbmode != 3'h1 &&
                                     s_reg.wbmode != 3'h2 ? 1'b0 : 1'b1,
                                     s_reg.gcst, 1'b0, s_reg.wout,
                                     1'b0, s_reg.gout};
        `ICU_A_RGAIN: s_next.rdata = {20'h0, s_reg.rg};
        `ICU_A_BGAIN: s_next.rdata = {20'h0, s_reg.bg};
        `ICU_A_REFGAIN: s_next.rdata = {4'h0, s_reg.gg, 4'h0, s_reg.ag};
        `ICU_A_REXP: s_next.rdata = {16'h0, s_reg.er};
        `ICU_A_BEXP: s_next.rdata = {16'h0, s_reg.eb};
        `ICU_A_GEXP: s_next.rdata = {16'h0, s_reg.eg};
        `ICU_A_ISTAT: begin
          s_next.rdata = {29'h0, s_reg.ist};
          s_next.ist   = 3'h0;
        end
        `ICU_A_IMASK: s_next.rdata = {29'h0, s_reg.imask};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    s_next.ist = s_next.ist | ev;
    s_next.irq = |(s_next.ist & s_next.imask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      s_reg        <= '0;
      s_reg.rg     <= `ICU_GAIN_RST;
      s_reg.bg     <= `ICU_GAIN_RST;
      s_reg.ag     <= `ICU_GAIN_RST;
      s_reg.gg     <= `ICU_GAIN_RST;
      s_reg.er     <= `ICU_EXP_RST;
      s_reg.eb     <= `ICU_EXP_RST;
      s_reg.eg     <= `ICU_EXP_RST;
      s_reg.wb_w   <= `ICU_WIN_RST;
      s_reg.area   <= icu_pkg::AREA_U1;
      s_reg.slot   <= 2'h1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o                 = s_reg.rdata;
  assign red_offset_o            = s_reg.off_r;
  assign green_offset_o          = s_reg.off_g;
  assign blue_offset_o           = s_reg.off_b;
  assign red_digital_gain_o      = s_reg.rg;
  assign blue_digital_gain_o     = s_reg.bg;
  assign red_exposure_o          = s_reg.er;
  assign blue_exposure_o         = s_reg.eb;
  assign wb_window_width_o       = s_reg.wb_w;
  assign wb_window_start_o       = s_reg.wb_x;
  assign gain_cal_store_o        = s_reg.gstore;
  assign gain_corr_target_area_o = s_reg.area;
  assign config_slot_store_o     = s_reg.cstore;
  assign config_slot_recall_o    = s_reg.crecall;
  assign config_slot_select_o    = s_reg.slot;
  assign irq_o                   = s_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking icu_cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_reg);

  gcal_refuse_a: assert property ( // see RULE4
    (s_reg.gcst == icu_pkg::GC_IDLE && wr_i && addr_i == `ICU_A_CMD &&
     wdata_i[0] && synthetic_image_select_i)
    |=> s_reg.gout == icu_pkg::OUT_ERR3 && s_reg.gcst == icu_pkg::GC_IDLE)
    else $error("gain calibration not refused");
  gcal_store_a: assert property ( // see RULE2
    gain_cal_store_o |-> s_reg.gout == icu_pkg::OUT_OK &&
    s_reg.area >= icu_pkg::AREA_U1 && $past(s_reg.gcst) == icu_pkg::GC_RUN)
    else $error("gain data stored without success");
  gcal_busy_a: assert property ( // see RULE18
    (s_reg.gcst == icu_pkg::GC_RUN &&
     s_reg.gcnt != 16'(GCAL_CYCLES - 1))
    |=> s_reg.gcst == icu_pkg::GC_RUN &&
        s_reg.gcnt == $past(s_reg.gcnt) + 16'h0001)
    else $error("calibration restarted while running");
  offset_range_a: assert property ( // see RULE5
    $signed(red_offset_o) >= `ICU_OFF_MIN &&
    $signed(red_offset_o) <= `ICU_OFF_MAX)
    else $error("red offset out of range");
  wb_lock_a: assert property ( // see RULE8
    (s_reg.wbmode == icu_pkg::WB_ONCE && s_reg.lock)
    |=> s_reg.wbmode == icu_pkg::WB_OFF && s_reg.wout == icu_pkg::OUT_OK)
    else $error("locked balance did not report success");
  wb_expmode_a: assert property ( // see RULE7
    $rose(s_reg.wbmode == icu_pkg::WB_EXPONCE) |-> s_reg.expind)
    else $error("exposure balance without individual mode");
  wb_preset_a: assert property ( // see RULE13
    $rose(s_reg.wbmode == icu_pkg::WB_P5000) |-> !s_reg.pcg &&
    red_digital_gain_o == `ICU_P5000_R)
    else $error("preset with per-channel gain on");
  cfg_store_a: assert property ( // see RULE15
    (wr_i && addr_i == `ICU_A_CMD && wdata_i[1] && acq_running_i)
    |=> !config_slot_store_o ##0 s_reg.ist[2])
    else $error("store accepted while acquiring");
  cfg_recall_a: assert property ( // see RULE16
    config_slot_recall_o |-> !$past(acq_running_i))
    else $error("recall accepted while acquiring");
  cfg_default_a: assert property ( // see RULE17
    config_slot_store_o |-> config_slot_select_o != 2'h0)
    else $error("factory slot overwritten");
endmodule

// ==== verilog/icu_consts.svh ====
// Purpose: Offsets, fields, reset values and timing counts.
// Assumes: Word-indexed register port, 10 MHz clock.
// Notes:   Definitions only.
`ifndef ICU_CONSTS_SVH
`define ICU_CONSTS_SVH
// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define ICU_A_CTRL     4'h0
`define ICU_A_CMD      4'h1
`define ICU_A_OSEL     4'h2
`define ICU_A_OVAL     4'h3
`define ICU_A_WBCTL    4'h4
`define ICU_A_WBWIN    4'h5
`define ICU_A_STAT     4'h6
`define ICU_A_RGAIN    4'h7
`define ICU_A_BGAIN    4'h8
`define ICU_A_REFGAIN  4'h9
`define ICU_A_REXP     4'ha
`define ICU_A_BEXP     4'hb
`define ICU_A_GEXP     4'hc
`define ICU_A_ISTAT    4'hd
`define ICU_A_IMASK    4'he
// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define ICU_CMD_GCAL   0
`define ICU_CMD_STORE  1
`define ICU_CMD_RECALL 2
`define ICU_OFF_MIN    (-10'sd133)
`define ICU_OFF_MAX    (10'sd255)
`define ICU_GAIN_MAX   12'hfff
`define ICU_GAIN_MIN   12'h001
`define ICU_GAIN_RST   12'h100
`define ICU_EXP_RST    16'h0100
`define ICU_P5000_R    12'h120
`define ICU_P5000_B    12'h0e0
`define ICU_P5500_R    12'h110
`define ICU_P5500_B    12'h0f0
`define ICU_LVL_BRIGHT 10'h3a0
`define ICU_LVL_DARK   10'h0c0
`define ICU_WB_TOL     10'h008
`define ICU_WIN_RST    13'h1000
`define ICU_CLK_HZ     10000000
`define ICU_WB_TMO_S   10
`define ICU_WB_TMO_CYC (`ICU_WB_TMO_S * `ICU_CLK_HZ)
`endif

// ==== verilog/icu_pkg.sv ====
// Purpose: Types shared by the image calibration controller.
// Assumes: Nothing.
// Notes:   Values live in icu_consts.svh.
package icu_pkg;
  typedef enum logic [2:0] {
    OUT_IDLE = 3'h0, OUT_OK = 3'h1, OUT_ERR1 = 3'h2,
    OUT_ERR2 = 3'h3, OUT_ERR3 = 3'h4
  } icu_outcome_type;
  typedef enum logic [2:0] {
    WB_OFF = 3'h0, WB_ONCE = 3'h1, WB_EXPONCE = 3'h2,
    WB_P5000 = 3'h3, WB_P5500 = 3'h4
  } icu_wbmode_type;
  typedef enum logic {GC_IDLE = 1'b0, GC_RUN = 1'b1} icu_gcst_type;
  typedef enum logic [2:0] {
    AREA_OFF = 3'h0, AREA_DEF = 3'h1, AREA_U1 = 3'h2,
    AREA_U2 = 3'h3, AREA_U3 = 3'h4
  } icu_area_type;
endpackage

// ==== testbench/icu_host.sv ====
// Purpose: Host model driving the register port of the controller.
// Assumes: Strobes one cycle long; read data stand the cycle after.
// Notes:   Tasks are called from the testbench top.
module icu_host (
  // Clock and read data
  input  wire logic        clock_i,
  input  wire logic [31:0] rdata_i,
  // Register port requests
  output logic      [3:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o  = 4'h0;
    wdata_o = 32'h0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // Released write data are inverted so stale values never look valid.
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o   <= 1'b0;
    @(posedge clock_i);
    d = rdata_i;
  endtask
endmodule

// ==== testbench/tb_image_calibration_and_user_sets.sv ====
// Purpose: Self-checking bench for the image calibration controller.
// Assumes: Short calibration, step and timeout counts.
// Notes:   Pulse outputs are counted by a monitor.
module tb_image_calibration_and_user_sets;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0, nrst_i = 1'b0, img = 1'b0, pat = 1'b0, acq = 1'b0;
  logic [9:0] cal = 10'h200, rl = 10'h200, gl = 10'h200, bl = 10'h200;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v;
  logic wr, rd, gst, cst, crc, irq;
  logic [9:0] ro, go, bo;
  logic [12:0] ww, wx;
  logic [2:0] area;
  int n_mismatch = 0, total_checks = 0, ng = 0, nc = 0, nr = 0;
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    ng <= ng + int'(gst);
    nc <= nc + int'(cst);
    nr <= nr + int'(crc);
  end
  icu_host host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  icu_top #(.GCAL_CYCLES(8), .WB_STEP(2), .WB_TMO(200)) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .image_out_i(img),
    .synthetic_image_select_i(pat), .acq_running_i(acq),
    .cal_level_i(cal), .red_level_i(rl), .green_level_i(gl),
    .blue_level_i(bl), .red_offset_o(ro), .green_offset_o(go),
    .blue_offset_o(bo), .red_digital_gain_o(), .blue_digital_gain_o(),
    .red_exposure_o(), .blue_exposure_o(), .wb_window_width_o(ww),
    .wb_window_start_o(wx), .gain_cal_store_o(gst),
    .gain_corr_target_area_o(area), .config_slot_store_o(cst),
    .config_slot_recall_o(crc), .config_slot_select_o(), .irq_o(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    host.rd_reg(a, v);
    chk(v & m, exp);
  endtask
  // Polls the status word until the given busy bit drops.
  task automatic wait_idle(input int b);
    int i;
    for (i = 0; i < 300; i++) begin
      host.rd_reg(4'h6, v);
      if (v[b] === 1'b0) break;
    end
    if (i == 300) n_mismatch++;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rchk(4'h6, 32'h77, 32'h0);
    rchk(4'h0, 32'hc7, 32'h42);
    host.wr_reg(4'h2, 32'h0);
    host.wr_reg(4'h3, 32'hffffff38);
    rchk(4'h3, 32'hffffffff, 32'hffffff7b);
    host.wr_reg(4'h2, 32'h2);
    host.wr_reg(4'h3, 32'h12c);
    @(posedge clock_i);
    chk({ro, go, bo}, {10'h37b, 10'h000, 10'h0ff});
    host.wr_reg(4'h5, 32'h00300100);
    rchk(4'h5, 32'hffffffff, 32'h00300100);
    chk({ww, wx}, {13'h0100, 13'h0030});
    $display("offsets done");
    host.wr_reg(4'h1, 32'h1);
    rchk(4'h6, 32'h107, 32'h4);
    img <= 1'b1;
    host.wr_reg(4'h0, 32'h41);
    host.wr_reg(4'h1, 32'h1);
    rchk(4'h6, 32'h107, 32'h4);
    host.wr_reg(4'h0, 32'h44);
    host.wr_reg(4'h1, 32'h1);
    host.wr_reg(4'h1, 32'h1);
    wait_idle(8);
    rchk(4'h6, 32'h7, 32'h1);
    chk(ng, 32'd1);
    chk({29'h0, area}, 32'h4);
    pat <= 1'b1;
    host.wr_reg(4'h1, 32'h1);
    rchk(4'h6, 32'h107, 32'h4);
    pat <= 1'b0;
    cal <= 10'h3f0;
    host.wr_reg(4'h1, 32'h1);
    wait_idle(8);
    rchk(4'h6, 32'h7, 32'h2);
    cal <= 10'h050;
    host.wr_reg(4'h1, 32'h1);
    wait_idle(8);
    rchk(4'h6, 32'h7, 32'h3);
    $display("gain calibration done");
    host.wr_reg(4'h4, 32'h3);
    rchk(4'h7, 32'hfff, 32'h120);
    host.wr_reg(4'h4, 32'h4);
    rchk(4'h8, 32'hfff, 32'h0f0);
    host.wr_reg(4'h0, 32'h4c);
    host.wr_reg(4'h4, 32'h3);
    rchk(4'h7, 32'hfff, 32'h110);
    host.wr_reg(4'h9, 32'h01400180);
    host.wr_reg(4'h0, 32'h44);
    host.wr_reg(4'h4, 32'h1);
    wait_idle(9);
    rchk(4'h6, 32'h70, 32'h10);
    rchk(4'h7, 32'hfff, 32'h180);
    rl <= 10'h100;
    gl <= 10'h300;
    bl <= 10'h100;
    host.wr_reg(4'h0, 32'h4c);
    host.wr_reg(4'h4, 32'h1);
    wait_idle(9);
    rchk(4'h6, 32'h70, 32'h40);
    rchk(4'h4, 32'h7, 32'h0);
    host.wr_reg(4'h0, 32'h6c);
    host.wr_reg(4'h4, 32'h1);
    wait_idle(9);
    rchk(4'h6, 32'h70, 32'h10);
    rchk(4'h4, 32'h7, 32'h0);
    host.wr_reg(4'h9, 32'h01400ffe);
    host.wr_reg(4'h0, 32'h44);
    host.wr_reg(4'h4, 32'h1);
    wait_idle(9);
    rchk(4'h6, 32'h70, 32'h20);
    rl <= 10'h300;
    gl <= 10'h100;
    bl <= 10'h300;
    host.wr_reg(4'h9, 32'h01400002);
    host.wr_reg(4'h4, 32'h1);
    wait_idle(9);
    rchk(4'h6, 32'h70, 32'h30);
    gl <= 10'h300;
    host.wr_reg(4'hc, 32'h0200);
    host.wr_reg(4'h0, 32'h54);
    host.wr_reg(4'h4, 32'h2);
    wait_idle(9);
    rchk(4'h6, 32'h70, 32'h10);
    rchk(4'ha, 32'hffff, 32'h0200);
    $display("white balance done");
    host.rd_reg(4'hd, v);
    host.wr_reg(4'he, 32'h4);
    acq <= 1'b1;
    host.wr_reg(4'h1, 32'h6);
    repeat (3) @(posedge clock_i);
    chk(nc, 32'd0);
    chk(nr, 32'd0);
    chk({31'h0, irq}, 32'h1);
    rchk(4'hd, 32'h7, 32'h4);
    acq <= 1'b0;
    host.wr_reg(4'h1, 32'h2);
    host.wr_reg(4'h0, 32'h04);
    host.wr_reg(4'h1, 32'h2);
    host.wr_reg(4'h1, 32'h4);
    repeat (3) @(posedge clock_i);
    chk(nc, 32'd1);
    chk(nr, 32'd1);
    rchk(4'hd, 32'h4, 32'h4);
    rchk(4'hd, 32'h4, 32'h0);
    $display("configuration slots done");
    close_out();
  end
endmodule
